// *** pkg/ssb_pkg.sv ***
// Constants and types shared by the supply supervisor and breaker
package ssb_pkg;

    // Core clock rate in MHz
    localparam int CLK_MHZ = 125;

    // Delay and filter intervals in their own units
    localparam int RELEASE_DELAY_MS = 200;
    localparam int ASSERT_DELAY_US  = 32;
    localparam int OC_FILTER_US     = 20;
    localparam int PCYC_HOLD_MS     = 20;
    localparam int CON_HOLD_MS      = 20;

    // The same intervals as core clock cycles
    localparam int RELEASE_CYC = RELEASE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int ASSERT_CYC  = ASSERT_DELAY_US * CLK_MHZ;
    localparam int OC_CYC      = OC_FILTER_US * CLK_MHZ;
    localparam int PCYC_CYC    = PCYC_HOLD_MS * 1000 * CLK_MHZ;
    localparam int CON_CYC     = CON_HOLD_MS * 1000 * CLK_MHZ;

    // Threshold select pin states and threshold codes
    localparam logic [1:0] PIN_FLOAT = 2'h0;
    localparam logic [1:0] PIN_RAIL  = 2'h1;
    localparam logic [1:0] PIN_GND   = 2'h2;
    localparam logic [1:0] THR_4V65  = 2'h0;
    localparam logic [1:0] THR_2V90  = 2'h1;
    localparam logic [1:0] THR_5V88  = 2'h2;

    // Bit positions in the synchronised input vector
    localparam int SYNC_W     = 11;
    localparam int IX_MAIN    = 0;
    localparam int IX_FB_LO   = 1;
    localparam int IX_FB_HI   = 2;
    localparam int IX_OC_LO   = 3;
    localparam int IX_OC_HI   = 4;
    localparam int IX_IN_LO   = 5;
    localparam int IX_IN_HI   = 6;
    localparam int IX_CON_A   = 7;
    localparam int IX_CON_B   = 8;
    localparam int IX_PCYC_N  = 9;
    localparam int IX_DRAINED = 10;
    localparam logic [SYNC_W-1:0] SYNC_RST = 11'h200;

    // Power path states
    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_ON    = 2'b01,
        ST_CYCLE = 2'b10,
        ST_DRAIN = 2'b11
    } ssb_pwr_t;

endpackage

// *** pkg/ssb_tmr_if.sv ***
// Condition and done pair between the supervisor and a qualification timer
`timescale 1ns/100ps
interface ssb_tmr_if;
    logic cond;
    logic done;
    modport ctl (output cond, input done);
    modport tmr (input cond, output done);
endinterface

// *** verilog/ssb_qual_timer.sv ***
// Qualification timer: done once its condition has held for LEN cycles
`timescale 1ns/100ps
module ssb_qual_timer #(
    parameter int LEN = 4000
) (
    input  wire logic core_clk,      // Core clock
    input  wire logic rst,           // Asynchronous reset, active high
    ssb_tmr_if.tmr    tif            // Condition in, done out
);

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_V = CW'(LEN);
    localparam logic [CW-1:0] ONE_V = CW'(1);

    if (LEN < 1)
    begin : g_chk
        $error("ssb_qual_timer: LEN must be at least one");
    end

    logic [CW-1:0] cnt_ff;

    // Any drop of the condition restarts from zero; count saturates
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= '0;
        else if (!tif.cond)
            cnt_ff <= '0;
        else if (cnt_ff != LEN_V)
            cnt_ff <= cnt_ff + ONE_V;
    end

    assign tif.done = (cnt_ff == LEN_V);

endmodule

// *** verilog/ssb_supervisor.sv ***
// Supply supervisor, delayed reset and circuit breaker for a hot-plug board
// Notes on behaviour
// - Supply-good rises at once with rail above threshold
// - Reset releases after supply-good holds 200ms
// - Supply-good falls at once with rail below
// - Reset asserts after supply-good low 32us
// - Short rise: supply-good follows, reset stays
// - Short dip: supply-good follows, reset stays released
// - Threshold code chosen from select pin state
// - Pin grounded 32us forces top threshold, reset
// - Reset held 200ms after pin released
// - Gates off until both input rails good
// - Breaker trips on overcurrent held over 20us
// - Trip: gates, fault, supply-good off; reset later
// - Trip latched until power cycle or rails removed
// - Power-cycle request needs 20ms low hold
// - Accepted power cycle clears breaker trip
// - Reset forced by connect, cycle or lockout
// - Bus disable drops together with reset release
`timescale 1ns/100ps
module ssb_supervisor #(
    parameter int REL_CYC  = ssb_pkg::RELEASE_CYC,
    parameter int PCYC_CYC = ssb_pkg::PCYC_CYC,
    parameter int CON_CYC  = ssb_pkg::CON_CYC
) (
    input  wire logic       core_clk,              // Core clock, 125 MHz
    input  wire logic       rst,                   // Asynchronous reset, active high
    input  wire logic       main_rail_comparator,  // Low output rail above threshold
    input  wire logic [1:0] threshold_select_pin,  // Select pin state
    input  wire logic       low_rail_current_sense,  // Low rail sense over limit
    input  wire logic       high_rail_current_sense, // High rail sense over limit
    input  wire logic       low_input_rail_ok,     // Low input rail above lockout
    input  wire logic       high_input_rail_ok,    // High input rail above lockout
    input  wire logic       connect_sense_a,       // Connect sense, high = open
    input  wire logic       connect_sense_b,       // Connect sense, high = open
    input  wire logic       power_cycle_req_n,     // Power-cycle request, low
    input  wire logic       discharge_done,        // Outputs below discharge level
    output logic            supply_good,           // Supply good flag
    output logic            reset_n,               // Delayed reset, low = reset
    output logic            fault_n,               // Breaker fault, low = tripped
    output logic            bus_disable,           // Board data bus disable
    output logic            low_rail_gate_drive,   // Low rail gate enable
    output logic            high_rail_gate_drive,  // High rail gate enable
    output logic            pump_on_indicator,     // Charge pumps running
    output logic [1:0]      threshold_code         // Selected reset threshold
);

    if (REL_CYC < 1 || PCYC_CYC < 1 || CON_CYC < 1)
    begin : g_chk
        $error("ssb_supervisor: delay counts must be at least one");
    end

    // Maps the three-state select pin to a threshold code
    function automatic logic [1:0] thr_of(input logic [1:0] pin);
        logic [1:0] code;
        code = ssb_pkg::THR_4V65;
        case (pin)
            ssb_pkg::PIN_FLOAT: code = ssb_pkg::THR_4V65;
            ssb_pkg::PIN_RAIL:  code = ssb_pkg::THR_2V90;
            ssb_pkg::PIN_GND:   code = ssb_pkg::THR_5V88;
            default:            code = ssb_pkg::THR_4V65;
        endcase
        return code;
    endfunction

    logic [ssb_pkg::SYNC_W-1:0] raw_in;
    logic [ssb_pkg::SYNC_W-1:0] sync1_ff;
    logic [ssb_pkg::SYNC_W-1:0] sync2_ff;

    assign raw_in = {discharge_done, power_cycle_req_n, connect_sense_b,
                     connect_sense_a, high_input_rail_ok, low_input_rail_ok,
                     high_rail_current_sense, low_rail_current_sense,
                     threshold_select_pin, main_rail_comparator};

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= ssb_pkg::SYNC_RST;
            sync2_ff <= ssb_pkg::SYNC_RST;
        end
        else
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    logic       rail_up;
    logic [1:0] fb_pin;
    logic       in_lo_ok;
    logic       in_hi_ok;
    logic       con_open;
    logic       pcyc_low;
    logic       drained;

    assign rail_up  = sync2_ff[ssb_pkg::IX_MAIN];
    assign fb_pin   = sync2_ff[ssb_pkg::IX_FB_HI:ssb_pkg::IX_FB_LO];
    assign in_lo_ok = sync2_ff[ssb_pkg::IX_IN_LO];
    assign in_hi_ok = sync2_ff[ssb_pkg::IX_IN_HI];
    assign con_open = sync2_ff[ssb_pkg::IX_CON_A] | sync2_ff[ssb_pkg::IX_CON_B];
    assign pcyc_low = ~sync2_ff[ssb_pkg::IX_PCYC_N];
    assign drained  = sync2_ff[ssb_pkg::IX_DRAINED];

    ssb_tmr_if rel_if ();
    ssb_tmr_if ast_if ();
    ssb_tmr_if fb_if ();
    ssb_tmr_if pcyc_if ();
    ssb_tmr_if con_if ();
    ssb_tmr_if oc_if [2] ();

    logic            supply_good_ff;
    logic            reset_n_ff;
    logic            fault_n_ff;
    logic            bus_disable_ff;
    logic            gate_ff;
    logic [1:0]      thr_ff;
    logic            trip_ff;
    ssb_pkg::ssb_pwr_t state_ff;
    ssb_pkg::ssb_pwr_t nxt_state;
    logic            nxt_trip;
    logic            nxt_good;
    logic            trip_set;
    logic            trip_clr;
    logic            lockout;
    logic            force_reset;
    logic            power_ok;

    // every timer restarts whenever its condition drops
    ssb_qual_timer #(.LEN(REL_CYC)) u_rel_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (rel_if)
    );

    ssb_qual_timer #(.LEN(ssb_pkg::ASSERT_CYC)) u_ast_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (ast_if)
    );

    ssb_qual_timer #(.LEN(ssb_pkg::ASSERT_CYC)) u_fb_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (fb_if)
    );

    ssb_qual_timer #(.LEN(PCYC_CYC)) u_pcyc_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (pcyc_if)
    );

    ssb_qual_timer #(.LEN(CON_CYC)) u_con_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (con_if)
    );

    logic [1:0] oc_sense;
    assign oc_sense = {sync2_ff[ssb_pkg::IX_OC_HI], sync2_ff[ssb_pkg::IX_OC_LO]};

    // one overcurrent filter per sense input
    for (genvar g = 0; g < 2; g++)
    begin : g_oc
        assign oc_if[g].cond = oc_sense[g];
        ssb_qual_timer #(.LEN(ssb_pkg::OC_CYC)) u_oc_tmr (
            .core_clk (core_clk),
            .rst      (rst),
            .tif      (oc_if[g])
        );
    end

    // release window needs supply-good and no forcing cause
    assign rel_if.cond  = supply_good_ff & ~force_reset;
    assign ast_if.cond  = ~supply_good_ff;
    assign fb_if.cond   = (fb_pin == ssb_pkg::PIN_GND);
    assign pcyc_if.cond = pcyc_low;
    assign con_if.cond  = ~con_open;

    assign lockout = ~in_lo_ok | ~in_hi_ok;

    assign trip_set = oc_if[0].done | oc_if[1].done;
    // clear by power cycle or by removing both inputs
    // accepted power cycle clears the breaker
    assign trip_clr = pcyc_if.done | (~in_lo_ok & ~in_hi_ok);
    // Set wins over clear so a trip in the clearing cycle is kept
    assign nxt_trip = trip_set | (trip_ff & ~trip_clr);

    // causes that hold reset regardless of the delays
    assign force_reset = con_open | lockout | (state_ff == ssb_pkg::ST_CYCLE)
                       | (state_ff == ssb_pkg::ST_DRAIN);

    // gates need both input rails out of lockout
    assign power_ok = ~lockout & con_if.done & ~nxt_trip;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            trip_ff <= 1'b0;
        else
            trip_ff <= nxt_trip;
    end

    // Power path sequencing
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ssb_pkg::ST_OFF:
            begin
                if (pcyc_if.done)
                    nxt_state = ssb_pkg::ST_CYCLE;
                else if (power_ok)
                    nxt_state = ssb_pkg::ST_ON;
            end
            ssb_pkg::ST_ON:
            begin
                if (pcyc_if.done)
                    nxt_state = ssb_pkg::ST_CYCLE;
                else if (!power_ok)
                    nxt_state = ssb_pkg::ST_OFF;
            end
            ssb_pkg::ST_CYCLE:
            begin
                if (!pcyc_low)
                    nxt_state = ssb_pkg::ST_DRAIN;
            end
            ssb_pkg::ST_DRAIN:
            begin
                // Power-up waits until the outputs have bled down
                if (pcyc_if.done)
                    nxt_state = ssb_pkg::ST_CYCLE;
                else if (drained)
                    nxt_state = ssb_pkg::ST_OFF;
            end
            default:
                nxt_state = ssb_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_ff <= ssb_pkg::ST_OFF;
        else
            state_ff <= nxt_state;
    end

    // accepted request turns the gates off
    // a trip drops the gates in the same cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            gate_ff <= 1'b0;
        else
            gate_ff <= (nxt_state == ssb_pkg::ST_ON);
    end

    // fault flag follows the latched trip
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            fault_n_ff <= 1'b1;
        else
            fault_n_ff <= ~nxt_trip;
    end

    // grounding only takes effect once it has held
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            thr_ff <= ssb_pkg::THR_4V65;
        else if (fb_pin != ssb_pkg::PIN_GND)
            thr_ff <= thr_of(fb_pin);
        else if (fb_if.done)
            thr_ff <= ssb_pkg::THR_5V88;
    end

    // rise with the rail, no delay
    // fall with the rail, no delay
    // forced top threshold pulls supply-good low
    assign nxt_good = rail_up & ~fb_if.done & ~nxt_trip;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            supply_good_ff <= 1'b0;
        else
            supply_good_ff <= nxt_good;
    end

    // short rises never reach the release count
    // short dips never reach the assertion count
    // after pin release the 200ms release window runs again
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reset_n_ff <= 1'b0;
        // forced causes win over both delays
        else if (force_reset)
            reset_n_ff <= 1'b0;
        else if (rel_if.done)
            reset_n_ff <= 1'b1;
        // assert after supply-good has stayed low for the 32us assertion delay
        else if (ast_if.done)
            reset_n_ff <= 1'b0;
    end

    // bus disable tracks the reset output edge for edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            bus_disable_ff <= 1'b1;
        else if (force_reset)
            bus_disable_ff <= 1'b1;
        else if (rel_if.done)
            bus_disable_ff <= 1'b0;
        else if (ast_if.done)
            bus_disable_ff <= 1'b1;
    end

    assign supply_good          = supply_good_ff;
    assign reset_n              = reset_n_ff;
    assign fault_n              = fault_n_ff;
    assign bus_disable          = bus_disable_ff;
    assign low_rail_gate_drive  = gate_ff;
    assign high_rail_gate_drive = gate_ff;
    assign pump_on_indicator    = gate_ff;
    assign threshold_code       = thr_ff;

endmodule

// *** verification/ssb_supervisor_props.sv ***
// Concurrent checks on the supply supervisor ports
`timescale 1ns/100ps
module ssb_supervisor_props #(
    parameter int REL_CYC = 50
) (
    input wire logic       core_clk,                // Clock
    input wire logic       rst,                     // Reset
    input wire logic       main_rail_comparator,    // Rail above
    input wire logic [1:0] threshold_select_pin,    // Select pin
    input wire logic       low_rail_current_sense,  // Sense low
    input wire logic       high_rail_current_sense, // Sense high
    input wire logic       low_input_rail_ok,       // Rail ok
    input wire logic       high_input_rail_ok,      // Rail ok
    input wire logic       connect_sense_a,         // Connect
    input wire logic       connect_sense_b,         // Connect
    input wire logic       power_cycle_req_n,       // Cycle request
    input wire logic       supply_good,             // Good flag
    input wire logic       reset_n,                 // Reset out
    input wire logic       fault_n,                 // Fault out
    input wire logic       bus_disable,             // Bus disable
    input wire logic       low_rail_gate_drive,     // Gate
    input wire logic       high_rail_gate_drive,    // Gate
    input wire logic [1:0] threshold_code           // Code
);
    localparam int LOW_LIM = 4010;
    int sg_high_ff;
    int sg_low_ff;
    int oc_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Run lengths at the ports, so delays are judged on raw pins
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sg_high_ff <= 0;
            sg_low_ff  <= 0;
            oc_ff      <= 0;
        end
        else
        begin
            sg_high_ff <= supply_good ? sg_high_ff + 1 : 0;
            sg_low_ff  <= supply_good ? 0 : sg_low_ff + 1;
            oc_ff      <= (low_rail_current_sense || high_rail_current_sense) ? oc_ff + 1 : 0;
        end
    end

    AST_SG_RISE: assert property ($rose(supply_good) |-> $past(main_rail_comparator, 3))
        else $error("supply good rose without rail above threshold");
    AST_REL_DELAY: assert property ($rose(reset_n) |-> sg_high_ff >= REL_CYC)
        else $error("reset released before release delay");
    AST_SG_FALL: assert property (!main_rail_comparator [*3] |=> !supply_good)
        else $error("supply good stayed high with rail low");
    AST_ASSERT_DELAY: assert property (sg_low_ff >= LOW_LIM |-> !reset_n)
        else $error("reset not asserted after supply good low");
    AST_THR_RAIL: assert property ((threshold_select_pin == ssb_pkg::PIN_RAIL) [*3]
        |=> threshold_code == ssb_pkg::THR_2V90) else $error("wrong threshold code");
    AST_LOCKOUT: assert property ((low_rail_gate_drive || high_rail_gate_drive)
        |-> $past(low_input_rail_ok, 3) && $past(high_input_rail_ok, 3))
        else $error("gates on with an input rail low");
    AST_OC_FILTER: assert property ($fell(fault_n) |-> oc_ff >= 2500)
        else $error("breaker tripped on short overcurrent");
    AST_TRIP_OFF: assert property ($fell(fault_n)
        |-> !low_rail_gate_drive && !high_rail_gate_drive && !supply_good)
        else $error("trip left gates or supply good on");
    AST_TRIP_HOLD: assert property ($rose(fault_n) |-> !$past(power_cycle_req_n, 3)
        || (!$past(low_input_rail_ok, 3) && !$past(high_input_rail_ok, 3)))
        else $error("trip cleared without a clearing cause");
    AST_CON_FORCE: assert property ((connect_sense_a || connect_sense_b) [*3] |=> !reset_n)
        else $error("reset released while unconnected");
    AST_BUS_DIS: assert property (bus_disable == !reset_n)
        else $error("bus disable not inverse of reset");

    cover property ($rose(reset_n));
    cover property ($fell(fault_n));
    cover property ($rose(fault_n));
endmodule

bind ssb_supervisor ssb_supervisor_props #(.REL_CYC(REL_CYC)) u_props (
    .core_clk, .rst, .main_rail_comparator, .threshold_select_pin, .low_rail_current_sense,
    .high_rail_current_sense, .low_input_rail_ok, .high_input_rail_ok, .connect_sense_a,
    .connect_sense_b, .power_cycle_req_n, .supply_good, .reset_n, .fault_n, .bus_disable,
    .low_rail_gate_drive, .high_rail_gate_drive, .threshold_code
);

// *** verification/ssb_host_model.sv ***
// Host model that pulls the active-low power-cycle request
`timescale 1ns/100ps
module ssb_host_model (
    input  wire logic        core_clk,          // Clock
    input  wire logic        rst,               // Reset
    input  wire logic        start,             // Begin a pulse
    input  wire logic [15:0] hold_cyc,          // Low time in cycles
    output logic             power_cycle_req_n  // Request, low active
);
    logic [15:0] cnt_ff;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= 16'h0000;
        else if (start)
            cnt_ff <= hold_cyc;
        else if (cnt_ff != 16'h0000)
            cnt_ff <= cnt_ff - 16'h0001;
    end

    assign power_cycle_req_n = (cnt_ff == 16'h0000);
endmodule

// *** verification/supply_supervisor_breaker_tb_top.sv ***
// Testbench for the supply supervisor and breaker
`timescale 1ns/100ps
module supply_supervisor_breaker_tb_top;
    localparam int REL = 50;
    logic        core_clk, rst, main_rail_comparator, low_rail_current_sense;
    logic        high_rail_current_sense, low_input_rail_ok, high_input_rail_ok;
    logic        connect_sense_a, connect_sense_b, power_cycle_req_n, discharge_done;
    logic        supply_good, reset_n, fault_n, bus_disable, pump_on_indicator;
    logic        low_rail_gate_drive, high_rail_gate_drive, host_start;
    logic [1:0]  threshold_select_pin, threshold_code;
    logic [15:0] host_hold;
    int          bad_count, compares, cyc;
    // Rows of {select pin, expected code}; pin value 3 reads as floating
    // Each row changes the code, so a stuck decoder cannot pass
    logic [3:0]  rows [4] = '{4'h5, 4'hC, 4'h5, 4'h0};

    ssb_supervisor #(.REL_CYC(REL), .PCYC_CYC(20), .CON_CYC(10)) DUT (
        .core_clk, .rst, .main_rail_comparator, .threshold_select_pin, .low_rail_current_sense,
        .high_rail_current_sense, .low_input_rail_ok, .high_input_rail_ok, .connect_sense_a,
        .connect_sense_b, .power_cycle_req_n, .discharge_done, .supply_good, .reset_n,
        .fault_n, .bus_disable, .low_rail_gate_drive, .high_rail_gate_drive,
        .pump_on_indicator, .threshold_code
    );
    ssb_host_model HOST (
        .core_clk, .rst, .start(host_start), .hold_cyc(host_hold), .power_cycle_req_n
    );

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bounded wait, the caller compares afterwards
    task automatic wait_rst(input logic v, input int lim);
        int n;
        n = 0;
        while (reset_n !== v && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic host_pulse(input logic [15:0] len);
        host_hold  = len;
        host_start = 1'b1;
        tick(1);
        host_start = 1'b0;
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    initial
    begin
        {rst, connect_sense_a, connect_sense_b, discharge_done} = 4'hF;
        {main_rail_comparator, low_rail_current_sense, high_rail_current_sense} = 3'h0;
        {low_input_rail_ok, high_input_rail_ok, host_start} = 3'h0;
        threshold_select_pin = 2'h0;
        host_hold = 16'h0000;
        tick(5);
        rst = 1'b0;
        check("reset_n", reset_n, 1'b0);
        check("fault_n", fault_n, 1'b1);
        foreach (rows[i])
        begin
            threshold_select_pin = rows[i][3:2];
            tick(4);
            check("code", threshold_code, rows[i][1:0]);
        end
        {connect_sense_a, connect_sense_b, low_input_rail_ok} = 3'h1;
        tick(40);
        check("gate", low_rail_gate_drive, 1'b0);
        high_input_rail_ok = 1'b1;
        tick(20);
        check("gate", high_rail_gate_drive, 1'b1);
        check("pump", pump_on_indicator, 1'b1);
        main_rail_comparator = 1'b1;
        tick(4);
        check("supply_good", supply_good, 1'b1);
        tick(REL - 10);
        check("reset_n", reset_n, 1'b0);
        wait_rst(1'b1, 20);
        check("reset_n", reset_n, 1'b1);
        check("bus_disable", bus_disable, 1'b0);
        main_rail_comparator = 1'b0;
        tick(4);
        check("supply_good", supply_good, 1'b0);
        tick(100);
        check("reset_n", reset_n, 1'b1);
        main_rail_comparator = 1'b1;
        tick(4);
        main_rail_comparator = 1'b0;
        tick(3900);
        check("reset_n", reset_n, 1'b1);
        wait_rst(1'b0, 200);
        check("reset_n", reset_n, 1'b0);
        main_rail_comparator = 1'b1;
        tick(20);
        check("supply_good", supply_good, 1'b1);
        main_rail_comparator = 1'b0;
        tick(4);
        check("supply_good", supply_good, 1'b0);
        check("reset_n", reset_n, 1'b0);
        main_rail_comparator = 1'b1;
        wait_rst(1'b1, 100);
        threshold_select_pin = 2'h2;
        tick(100);
        check("reset_n", reset_n, 1'b1);
        wait_rst(1'b0, 8300);
        check("reset_n", reset_n, 1'b0);
        check("code", threshold_code, 2'h2);
        threshold_select_pin = 2'h0;
        tick(REL - 10);
        check("reset_n", reset_n, 1'b0);
        wait_rst(1'b1, 30);
        check("reset_n", reset_n, 1'b1);
        low_rail_current_sense = 1'b1;
        tick(2000);
        low_rail_current_sense = 1'b0;
        high_rail_current_sense = 1'b1;
        tick(2400);
        check("fault_n", fault_n, 1'b1);
        tick(200);
        high_rail_current_sense = 1'b0;
        check("fault_n", fault_n, 1'b0);
        check("gate", low_rail_gate_drive, 1'b0);
        check("supply_good", supply_good, 1'b0);
        check("reset_n", reset_n, 1'b1);
        wait_rst(1'b0, 4100);
        check("reset_n", reset_n, 1'b0);
        tick(100);
        check("fault_n", fault_n, 1'b0);
        host_pulse(16'h000A);
        tick(40);
        check("fault_n", fault_n, 1'b0);
        // Outputs not yet bled down, so power-up must wait
        discharge_done = 1'b0;
        host_pulse(16'h001E);
        tick(27);
        check("fault_n", fault_n, 1'b1);
        check("gate", high_rail_gate_drive, 1'b0);
        tick(40);
        check("gate", low_rail_gate_drive, 1'b0);
        discharge_done = 1'b1;
        tick(40);
        check("gate", low_rail_gate_drive, 1'b1);
        wait_rst(1'b1, 100);
        check("reset_n", reset_n, 1'b1);
        connect_sense_b = 1'b1;
        tick(4);
        check("reset_n", reset_n, 1'b0);
        wrap_up();
    end
endmodule
